// [core/pcsr_bank.sv]
// configuration register bank: phy control, lane mode, subsystem_device_code
`timescale 1ns/10ps
`default_nettype none
// How it works
// [R1] A read at C4 returns the capability id 0Dh in bits 7:0.
// [R2] A read at C4 returns the next pointer E0h in bits 15:8.
// [R3] Bits 15:0 at C8 hold the read-only vendor code, set by override only.
// [R4] Bits 31:16 at C8 hold the read-only device code, set by override only.
// [R5] Downstream amp resets to 10111b, reflects the strap, takes overrides.
// [R6] Upstream drive amplitude resets to 10111b and takes smbus only.
// [R7] Overridable fields load their reset value first, then any override.
// [R8] The link test word at B8 reads 30h, 00b, 0b and nibble 0100b.
// [R9] Reserved bits keep their pattern; writes to read-only bits do nothing.
module pcsr_bank
  import pcsr_pkg::*;
#(
  parameter bit IS_DOWNSTREAM = 1'h1
)
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   cfg_req,
  input  wire logic                   cfg_we,
  input  wire logic [7:0]             cfg_addr,
  input  wire logic [3:0]             cfg_be,
  input  wire logic [31:0]            cfg_wdata,
  output var  logic                   cfg_ack,
  output var  logic [31:0]            cfg_rdata,
  input  wire logic                   ovr_valid,
  input  wire pcsr_pkg::pcsr_src_type ovr_src,
  input  wire logic [7:0]             ovr_addr,
  input  wire logic [31:0]            ovr_data,
  input  wire logic [3:0]             ovr_be,
  input  wire logic                   low_drive_strap,
  output var  logic [4:0]             drive_amp,
  output var  logic [5:0]             pm_param,
  output var  logic                   rx_polarity_disable,
  output var  logic                   compliance_parity_disable,
  output var  logic [6:0]             lane_mode
);
  import pcsr_pkg::*;

  pcsr_ovr_if ovr_bus ();

  logic           strap_sync;
  logic [4:0]     amp_reg;
  logic [7:0]     opmode_reg;
  logic [6:0]     lane_reg;
  logic [31:0]    subsys_reg;
  logic           ack_reg;
  logic [31:0]    rdata_reg;
  logic [31:0]    rdata_next;
  logic [15:0]    opm_half;
  logic [1:0]     strap_cnt_reg;
  pcsr_strap_type strap_state_reg;
  logic           strap_load;
  logic           amp_ovr;
  logic           cfg_wr;

  pcsr_sync u_strap_sync
  (
    .clk      (clk),
    .reset    (reset),
    .async_in (low_drive_strap),
    .sync_out (strap_sync)
  );

  pcsr_ovr_decode u_ovr_decode
  (
    .clk       (clk),
    .reset     (reset),
    .ovr_valid (ovr_valid),
    .ovr_src   (ovr_src),
    .ovr_addr  (ovr_addr),
    .ovr_data  (ovr_data),
    .ovr_be    (ovr_be),
    .bus       (ovr_bus)
  );

  assign cfg_wr = cfg_req && cfg_we;

  // eeprom may not touch the upstream amplitude
  assign amp_ovr = ovr_bus.strobe && ovr_bus.hit_phy0 &&
                   ovr_bus.be[LANE_B2] &&
                   (IS_DOWNSTREAM || !ovr_bus.from_eeprom); // [R5] [R6]

  // strap capture once the synchroniser has settled
  assign strap_load = IS_DOWNSTREAM && (strap_state_reg == STRAP_WAIT) &&
                      (strap_cnt_reg == STRAP_SETTLE) && !amp_ovr; // [R5]

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      strap_state_reg <= STRAP_WAIT;
      strap_cnt_reg   <= 2'h0;
    end
    else
    begin
      case (strap_state_reg)
        STRAP_WAIT:
        begin
          strap_cnt_reg <= strap_cnt_reg + 2'h1;
          if (amp_ovr || (strap_cnt_reg == STRAP_SETTLE))
            strap_state_reg <= STRAP_DONE; // [R7]
        end
        STRAP_DONE:
          strap_state_reg <= STRAP_DONE;
        default:
          strap_state_reg <= STRAP_DONE;
      endcase
    end
  end

  // drive amplitude
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      amp_reg <= AMP_RESET; // [R5] [R6] [R7]
    else if (amp_ovr)
      amp_reg <= ovr_bus.data[AMP_MSB:AMP_LSB]; // [R7]
    else if (strap_load)
      amp_reg <= strap_sync ? AMP_LOW_DRIVE : AMP_RESET; // [R5]
  end

  // downstream operation mode bits 15:8
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      opmode_reg <= OPM_RESET;
    else if (IS_DOWNSTREAM && ovr_bus.strobe && ovr_bus.hit_phy0 &&
             ovr_bus.be[LANE_B1])
      opmode_reg <= ovr_bus.data[OPM_MSB:OPM_LSB]; // [R7]
    else if (IS_DOWNSTREAM && cfg_wr && (cfg_addr == OFS_PHY0) &&
             cfg_be[LANE_B1])
      opmode_reg <= cfg_wdata[OPM_MSB:OPM_LSB];
  end

  // lane mode, only bits 6:0 writable
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      lane_reg <= LANE_RESET;
    else if (cfg_wr && (cfg_addr == OFS_LANE) && cfg_be[LANE_B0])
      lane_reg <= cfg_wdata[LANE_MSB:0]; // [R9]
  end

  // subsystem codes, one byte lane per generate entry
  genvar b;
  generate
    for (b = 0; b < NUM_LANE; b++)
    begin : g_subsys
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          subsys_reg[b*BYTE_W +: BYTE_W] <=
            SUBSYS_RESET[b*BYTE_W +: BYTE_W]; // [R3] [R4] [R7]
        else if (ovr_bus.strobe && ovr_bus.hit_subsys && ovr_bus.be[b])
          subsys_reg[b*BYTE_W +: BYTE_W] <=
            ovr_bus.data[b*BYTE_W +: BYTE_W]; // [R3] [R4] [R7]
      end
    end
  endgenerate

  // low half of B4 only exists on the downstream side
  assign opm_half = IS_DOWNSTREAM ? {opmode_reg, OPM_LOW_RSV} : 16'h0000;

  // read multiplexer
  always_comb
  begin
    rdata_next = 32'h0;
    case (cfg_addr)
      OFS_PHY0:
        rdata_next = {1'h0, PHY0_RSV_HI, PHY0_RSV_MID, amp_reg,
                      opm_half}; // [R5] [R6] [R9]
      OFS_LINK:
        rdata_next = LINK_WORD; // [R8]
      OFS_PHY2:
        rdata_next = PHY2_WORD; // [R9]
      OFS_LANE:
        rdata_next = {25'h0, lane_reg}; // [R9]
      OFS_CAP:
        rdata_next = {16'h0000, NEXT_PTR, CAP_ID}; // [R1] [R2]
      OFS_SUBSYS:
        rdata_next = subsys_reg; // [R3] [R4]
      default:
        rdata_next = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_reg   <= 1'h0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg   <= cfg_req;
      rdata_reg <= (cfg_req && !cfg_we) ? rdata_next : 32'h0;
    end
  end

  assign cfg_ack                   = ack_reg;
  assign cfg_rdata                 = rdata_reg;
  assign drive_amp                 = amp_reg;
  assign pm_param                  = opmode_reg[OPM_PM_MSB:0];
  assign rx_polarity_disable       = opmode_reg[OPM_RXPOL_BIT];
  assign compliance_parity_disable = opmode_reg[OPM_COMPL_BIT];
  assign lane_mode                 = lane_reg;

  // helper copy of the override data for checks
  logic [31:0] ovr_data_d;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ovr_data_d <= 32'h0;
    else
      ovr_data_d <= ovr_bus.data;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence cap_read_s;
    cfg_req && !cfg_we && (cfg_addr == OFS_CAP);
  endsequence

  sequence subsys_read_s;
    cfg_req && !cfg_we && (cfg_addr == OFS_SUBSYS);
  endsequence

  sequence link_read_s;
    cfg_req && !cfg_we && (cfg_addr == OFS_LINK);
  endsequence

  sequence vendor_ovr_s;
    ovr_bus.strobe && ovr_bus.hit_subsys && ovr_bus.be[LANE_B0];
  endsequence

  cap_id_read_a: assert property ( // [R1]
    cap_read_s |=> cfg_ack && (cfg_rdata[7:0] == CAP_ID))
    else $error("capability id wrong");

  next_ptr_read_a: assert property ( // [R2]
    cap_read_s |=> (cfg_rdata[15:8] == NEXT_PTR) &&
                   (cfg_rdata[31:16] == 16'h0000))
    else $error("next pointer wrong");

  vendor_code_read_a: assert property ( // [R3]
    subsys_read_s |=> cfg_rdata[15:0] == $past(subsys_reg[15:0]))
    else $error("vendor code read wrong");

  device_code_read_a: assert property ( // [R4]
    subsys_read_s |=> cfg_rdata[31:16] == $past(subsys_reg[31:16]))
    else $error("device code read wrong");

  strap_amp_load_a: assert property ( // [R5]
    strap_load |=> drive_amp ==
      ($past(strap_sync) ? AMP_LOW_DRIVE : AMP_RESET))
    else $error("strap amplitude not loaded");

  upstream_amp_guard_a: assert property ( // [R6]
    !IS_DOWNSTREAM && ovr_bus.strobe && ovr_bus.hit_phy0 &&
    ovr_bus.from_eeprom |=> $stable(drive_amp))
    else $error("eeprom changed upstream amplitude");

  vendor_override_a: assert property ( // [R7]
    vendor_ovr_s |=> subsys_reg[7:0] == ovr_data_d[7:0])
    else $error("vendor override lost");

  link_word_read_a: assert property ( // [R8]
    link_read_s |=> (cfg_rdata[7:0] == FTS_COUNT) &&
                    (cfg_rdata[9:8] == SCRAMBLE) &&
                    (cfg_rdata[10] == BOTH_LOW) &&
                    (cfg_rdata[15:12] == TL_NIBBLE))
    else $error("link test word wrong");

  readonly_write_a: assert property ( // [R9]
    cfg_wr && (cfg_addr == OFS_SUBSYS) && !ovr_bus.strobe
      |=> $stable(subsys_reg))
    else $error("write changed read-only code");

  lane_reserved_a: assert property ( // [R9]
    cfg_req && !cfg_we && (cfg_addr == OFS_LANE)
      |=> cfg_rdata[31:7] == 25'h0)
    else $error("lane mode reserved bits set");

  phy0_reserved_a: assert property ( // [R9]
    cfg_req && !cfg_we && (cfg_addr == OFS_PHY0)
      |=> cfg_rdata[31:21] == {1'h0, PHY0_RSV_HI, PHY0_RSV_MID})
    else $error("amplitude reserved bits wrong");

endmodule // pcsr_bank
`default_nettype wire

// [core/pcsr_pkg.sv]
// constants and types for the phy control and subsystem_device_code register bank
package pcsr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_PHY0   = 8'hB4;
  localparam logic [7:0] OFS_LINK   = 8'hB8;
  localparam logic [7:0] OFS_PHY2   = 8'hBC;
  localparam logic [7:0] OFS_LANE   = 8'hC0;
  localparam logic [7:0] OFS_CAP    = 8'hC4;
  localparam logic [7:0] OFS_SUBSYS = 8'hC8;

  // byte lanes
  localparam int BYTE_W   = 8;
  localparam int LANE_B0  = 0;
  localparam int LANE_B1  = 1;
  localparam int LANE_B2  = 2;
  localparam int NUM_LANE = 4;

  // capability header
  localparam logic [7:0] CAP_ID   = 8'h0D;
  localparam logic [7:0] NEXT_PTR = 8'hE0;

  // phy control zero at B4
  localparam int AMP_LSB = 16;
  localparam int AMP_MSB = 20;
  localparam logic [4:0] AMP_RESET     = 5'h17;
  localparam logic [4:0] AMP_LOW_DRIVE = 5'h0F;
  localparam logic [4:0] PHY0_RSV_MID  = 5'h0D;
  localparam logic [4:0] PHY0_RSV_HI   = 5'h08;

  // downstream downstream_switch_op_mode, bits 15:8 of B4
  localparam int OPM_LSB = 8;
  localparam int OPM_MSB = 15;
  localparam logic [5:0] PM_PARAM_RESET = 6'h00;
  localparam logic [7:0] OPM_RESET      = {2'h0, PM_PARAM_RESET};
  localparam logic [7:0] OPM_LOW_RSV    = 8'h00;
  localparam int OPM_PM_MSB    = 5;
  localparam int OPM_RXPOL_BIT = 6;
  localparam int OPM_COMPL_BIT = 7;

  // link test word at B8
  localparam logic [7:0] FTS_COUNT  = 8'h30;
  localparam logic [1:0] SCRAMBLE   = 2'h0;
  localparam logic       BOTH_LOW   = 1'h0;
  localparam logic [3:0] TL_NIBBLE  = 4'h4;
  localparam logic [4:0] DEEMPH     = 5'h12;
  localparam logic [4:0] PHY1_RSV_M = 5'h0E;
  localparam logic [4:0] PHY1_RSV_H = 5'h15;
  localparam logic [31:0] LINK_WORD = {1'h0, PHY1_RSV_H, PHY1_RSV_M, DEEMPH,
                                       TL_NIBBLE, 1'h0, BOTH_LOW, SCRAMBLE,
                                       FTS_COUNT};

  // phy control two at BC
  localparam logic [31:0] PHY2_WORD = {1'h0, 1'h0, 4'h6, 4'h3, 2'h1, 4'h0,
                                       3'h0, 2'h3, 2'h3, 1'h0, 1'h0, 3'h2,
                                       4'h7};

  // lane mode at C0
  localparam int LANE_MSB = 6;
  localparam logic [6:0] LANE_RESET = 7'h00;

  // subsystem codes at C8, values arbitrary
  localparam logic [15:0] VENDOR_DEFAULT = 16'hA5C3;
  localparam logic [15:0] DEVICE_DEFAULT = 16'h3C5A;
  localparam logic [31:0] SUBSYS_RESET   = {DEVICE_DEFAULT, VENDOR_DEFAULT};

  // strap settling count after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic {OVR_SMBUS, OVR_EEPROM} pcsr_src_type;
  typedef enum logic {STRAP_WAIT, STRAP_DONE} pcsr_strap_type;

endpackage

// [core/pcsr_ovr_if.sv]
// override write carrier between decoder and register bank
`timescale 1ns/10ps
`default_nettype none
interface pcsr_ovr_if;
  logic        strobe;
  logic        from_eeprom;
  logic        hit_phy0;
  logic        hit_subsys;
  logic [31:0] data;
  logic [3:0]  be;

  modport decoder (output strobe, from_eeprom, hit_phy0, hit_subsys, data, be);
  modport bank    (input  strobe, from_eeprom, hit_phy0, hit_subsys, data, be);
endinterface
`default_nettype wire

// [core/pcsr_sync.sv]
// two flip-flop synchroniser for the strap pin
`timescale 1ns/10ps
`default_nettype none
module pcsr_sync
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta_reg;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_reg <= 1'h0;
      sync_out <= 1'h0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pcsr_sync
`default_nettype wire

// [core/pcsr_ovr_decode.sv]
// registers and decodes smbus or eeprom default overrides
`timescale 1ns/10ps
`default_nettype none
module pcsr_ovr_decode
  import pcsr_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  ovr_valid,
  input  wire pcsr_pkg::pcsr_src_type ovr_src,
  input  wire logic [7:0]            ovr_addr,
  input  wire logic [31:0]           ovr_data,
  input  wire logic [3:0]            ovr_be,
  pcsr_ovr_if.decoder                bus
);
  logic hit_phy0_next;
  logic hit_subsys_next;

  assign hit_phy0_next   = ovr_valid && (ovr_addr == OFS_PHY0);
  assign hit_subsys_next = ovr_valid && (ovr_addr == OFS_SUBSYS);

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      bus.strobe      <= 1'h0;
      bus.from_eeprom <= 1'h0;
      bus.hit_phy0    <= 1'h0;
      bus.hit_subsys  <= 1'h0;
      bus.data        <= 32'h0;
      bus.be          <= 4'h0;
    end
    else
    begin
      bus.strobe      <= hit_phy0_next || hit_subsys_next;
      bus.from_eeprom <= (ovr_src == OVR_EEPROM);
      bus.hit_phy0    <= hit_phy0_next;
      bus.hit_subsys  <= hit_subsys_next;
      bus.data        <= ovr_data;
      bus.be          <= ovr_be;
    end
  end
endmodule // pcsr_ovr_decode
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the phy control and subsystem_device_code bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import pcsr_pkg::*;
  logic         clk;
  logic         reset;
  logic         cfg_req;
  logic         cfg_we;
  logic [7:0]   cfg_addr;
  logic [3:0]   cfg_be;
  logic [31:0]  cfg_wdata;
  logic         ovr_valid;
  pcsr_src_type ovr_src;
  logic [7:0]   ovr_addr;
  logic [31:0]  ovr_data;
  logic [3:0]   ovr_be;
  logic         strap;
  logic         ack_dn;
  logic         ack_up;
  logic [31:0]  rd_dn;
  logic [31:0]  rd_up;
  logic [4:0]   amp_dn;
  logic [4:0]   amp_up;
  logic [5:0]   pm_dn;
  logic         rx_dn;
  logic         cp_dn;
  logic [6:0]   lane_dn;
  logic [5:0]   pm_up;
  logic         rx_up;
  logic         cp_up;
  logic [6:0]   lane_up;
  logic [31:0]  dn_b4;
  logic [31:0]  up_b4;
  logic [31:0]  lane_m;
  logic [31:0]  sub_m;
  logic [63:0]  e;
  logic [63:0]  expq[$];
  int           fail_count;
  int           n_tests;
  logic [7:0]   offs[0:7] = '{8'hB4, 8'hB8, 8'hBC, 8'hC0, 8'hC4, 8'hC8,
                              8'h00, 8'hCC};

  pcsr_bank #(.IS_DOWNSTREAM(1'h1)) i_pcsr_bank (.clk(clk), .reset(reset),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(ack_dn), .cfg_rdata(rd_dn),
    .ovr_valid(ovr_valid), .ovr_src(ovr_src), .ovr_addr(ovr_addr),
    .ovr_data(ovr_data), .ovr_be(ovr_be), .low_drive_strap(strap),
    .drive_amp(amp_dn), .pm_param(pm_dn), .rx_polarity_disable(rx_dn),
    .compliance_parity_disable(cp_dn), .lane_mode(lane_dn));

  pcsr_bank #(.IS_DOWNSTREAM(1'h0)) i_pcsr_bank_up (.clk(clk), .reset(reset),
    .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_ack(ack_up), .cfg_rdata(rd_up),
    .ovr_valid(ovr_valid), .ovr_src(ovr_src), .ovr_addr(ovr_addr),
    .ovr_data(ovr_data), .ovr_be(ovr_be), .low_drive_strap(strap),
    .drive_amp(amp_up), .pm_param(pm_up), .rx_polarity_disable(rx_up),
    .compliance_parity_disable(cp_up), .lane_mode(lane_up));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] expv(input logic [7:0] a, input bit dn);
    case (a)
      8'hB4: return dn ? dn_b4 : up_b4;
      8'hB8: return 32'h55D24030;
      8'hBC: return PHY2_WORD;
      8'hC0: return lane_m;
      8'hC4: return 32'h0000E00D;
      8'hC8: return sub_m;
      default: return 32'h0;
    endcase
  endfunction

  task automatic model_reset;
    dn_b4 = {1'b0, 5'b01000, 5'b01101, 5'b10111, 16'h0};
    up_b4 = dn_b4;
    lane_m = 32'h0;
    sub_m = SUBSYS_RESET;
  endtask

  task automatic acc(input logic we, input logic [7:0] a,
                     input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    {cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, we, a, b, d};
    if (we)
      expq.push_back(64'h0);
    else
      expq.push_back({expv(a, 1'b1), expv(a, 1'b0)});
  endtask

  task automatic idle;
    @(posedge clk);
    {cfg_req, ovr_valid} <= 2'b00;
  endtask

  task automatic rd_all;
    foreach (offs[i])
      acc(1'b0, offs[i], 4'hF, 32'h0);
    idle();
  endtask

  task automatic wr_all;
    logic [31:0] d;
    logic [3:0]  b;
    foreach (offs[i])
    begin
      d = $urandom;
      b = 4'($urandom);
      acc(1'b1, offs[i], b, d);
      if (offs[i] == 8'hB4 && b[1])
        dn_b4[15:8] = d[15:8];
      if (offs[i] == 8'hC0 && b[0])
        lane_m = {25'h0, d[6:0]};
    end
    idle();
  endtask

  task automatic ovr(input pcsr_src_type s, input logic [7:0] a);
    logic [31:0] d;
    logic [3:0]  b;
    d = $urandom;
    b = 4'($urandom);
    @(posedge clk);
    {ovr_valid, ovr_addr, ovr_be, ovr_data} <= {1'b1, a, b, d};
    ovr_src <= s;
    for (int k = 0; k < 4; k++)
      if (b[k] && a == 8'hC8)
        sub_m[8*k +: 8] = d[8*k +: 8];
    if (a == 8'hB4 && b[2])
      dn_b4[20:16] = d[20:16];
    if (a == 8'hB4 && b[2] && s == OVR_SMBUS)
      up_b4[20:16] = d[20:16];
    if (a == 8'hB4 && b[1])
      dn_b4[15:8] = d[15:8];
  endtask

  task automatic outs;
    @(negedge clk);
    check(32'(amp_dn), 32'(dn_b4[20:16]));
    check(32'(amp_up), 32'(up_b4[20:16]));
    check(32'(pm_dn), 32'(dn_b4[13:8]));
    check(32'({cp_dn, rx_dn}), 32'(dn_b4[15:14]));
    check(32'(lane_dn), lane_m);
    check(32'({lane_up, cp_up, rx_up, pm_up}), lane_m << 8);
  endtask

  always @(negedge clk)
  begin
    if (ack_dn === 1'b1 || ack_up === 1'b1)
    begin
      e = (expq.size() > 0) ? expq.pop_front() : {64{1'bx}};
      check(rd_dn, e[63:32]);
      check(rd_up, e[31:0]);
      check(32'({ack_dn, ack_up}), 32'h3);
    end
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    conclude();
  end

  initial
  begin
    void'($urandom(32'hD3AD00FC));
    {reset, cfg_req, cfg_we, cfg_addr, cfg_be, cfg_wdata} = {2'b10, 45'h0};
    {ovr_valid, ovr_addr, ovr_data, ovr_be, strap} = {1'b0, 44'h0, 1'b1};
    ovr_src = OVR_SMBUS;
    model_reset();
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    outs();
    repeat (6) @(posedge clk);
    dn_b4[20:16] = 5'b01111;
    outs();
    rd_all();
    wr_all();
    rd_all();
    outs();
    for (int r = 0; r < 6; r++)
    begin
      ovr(pcsr_src_type'(r % 2), 8'hC8);
      ovr(pcsr_src_type'(r % 2), 8'hB4);
      ovr(pcsr_src_type'(r % 2), 8'hB8);
      idle();
      repeat (2) @(posedge clk);
      rd_all();
      outs();
    end
    repeat (3) @(posedge clk);
    reset <= 1'b1;
    strap <= 1'b0;
    model_reset();
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    outs();
    rd_all();
    repeat (4) @(posedge clk);
    check(32'(expq.size()), 32'h0);
    conclude();
  end
endmodule // tb
`default_nettype wire
